/* verilog/drx_ctrl_bank.sv */
// Functional notes
// - shift data msb first on clock rise
// - keep only the latest 32 bits
// - strobe rise copies word to one register
// - low four bits select the destination
// - select decoded as unsigned index 0..15
// - balun cutoffs from register 13 fields
// - mixer lo bias from register 13
// - mixer v-to-i bias from register 13
// - register 13 bits enable each mixer
// - register 7 bit 22 picks gain source
// - serial gain codes from register 14
// - parallel pins give gain when selected
// - register 14 bits power down amplifiers
// - gain code is 0.5 dB steps downward
// - gain applies while latch high or rising
//
// top of the serial control bank of a dual receive downconverter
// assumes: all link and gain pins are asynchronous to sys_clk; serial clock
// far slower than sys_clk (125 ns in the bench)
`timescale 1ns/1ns
`include "drx_regs.svh"
module drx_ctrl_bank (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // serial link
  input  wire drx_pkg::drx_link_t  link_in,
  // parallel gain pins and latches
  input  wire drx_pkg::drx_gain_t  par_gain_a,
  input  wire drx_pkg::drx_gain_t  par_gain_b,
  input  wire logic                gain_latch_a,
  input  wire logic                gain_latch_b,
  // controls to analog
  output drx_pkg::drx_ctrl_t       ctrl_out,
  output drx_pkg::drx_gain_t       gain_a,
  output drx_pkg::drx_gain_t       gain_b,
  // shadow of the bank word that the current select names
  output drx_pkg::drx_word_t       last_word
);
  import drx_pkg::*;

  typedef struct packed {
    drx_link_t  l1;
    drx_link_t  l2;
    logic       sclk_prev;
    logic       strobe_prev;
    drx_gain_t  pa1;
    drx_gain_t  pa2;
    drx_gain_t  pb1;
    drx_gain_t  pb2;
    logic [1:0] la_s;
    logic [1:0] lb_s;
    drx_word_t  shift;
    drx_word_t  r_gsrc;
    drx_word_t  r_mix;
    drx_word_t  r_amp;
    drx_ctrl_t  ctrl;
    drx_gain_t  ga;
    drx_gain_t  gb;
  } drx_state_t;

  drx_state_t s_q, s_d;
  logic                  sclk_rise;
  logic                  strobe_rise;
  logic [`DRX_SEL_W-1:0] sel;
  drx_gain_t             src_a;
  drx_gain_t             src_b;
  logic                  rf_wr;

  // edges are found on the second synchroniser stage only
  assign sclk_rise   = s_q.l2.sclk & ~s_q.sclk_prev;
  assign strobe_rise = s_q.l2.load_strobe & ~s_q.strobe_prev;
  assign sel         = s_q.shift[`DRX_SEL_HI:`DRX_SEL_LO];
  assign rf_wr       = strobe_rise;

  // gain source mux; a pin change only matters once a latch lets it through
  assign src_a = s_q.r_gsrc[`DRX_GSRC_BIT] ? s_q.pa2 : s_q.r_amp[`DRX_GA_HI:`DRX_GA_LO];
  assign src_b = s_q.r_gsrc[`DRX_GSRC_BIT] ? s_q.pb2 : s_q.r_amp[`DRX_GB_HI:`DRX_GB_LO];

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for every pin
    s_d.l1          = link_in;
    s_d.l2          = s_q.l1;
    s_d.sclk_prev   = s_q.l2.sclk;
    s_d.strobe_prev = s_q.l2.load_strobe;
    s_d.pa1         = par_gain_a;
    s_d.pa2         = s_q.pa1;
    s_d.pb1         = par_gain_b;
    s_d.pb2         = s_q.pb1;
    s_d.la_s        = {s_q.la_s[0], gain_latch_a};
    s_d.lb_s        = {s_q.lb_s[0], gain_latch_b};
    // shifting continues regardless of strobe; old bits fall off the top
    if (sclk_rise) begin
      s_d.shift = {s_q.shift[`DRX_WORD_W-2:0], s_q.l2.sdata};
    end
    // local copies of the three registers that steer logic
    if (strobe_rise) begin
      unique case (sel)
        `DRX_IDX_GSRC: s_d.r_gsrc = s_q.shift;
        `DRX_IDX_MIX:  s_d.r_mix  = s_q.shift;
        `DRX_IDX_AMP:  s_d.r_amp  = s_q.shift;
        default:       s_d.r_gsrc = s_q.r_gsrc;
      endcase
    end
    // decode control fields
    s_d.ctrl.balun_in_cut  = s_q.r_mix[`DRX_CIN_HI:`DRX_CIN_LO];
    s_d.ctrl.balun_out_cut = s_q.r_mix[`DRX_COUT_HI:`DRX_COUT_LO];
    s_d.ctrl.mix_lo_bias   = s_q.r_mix[`DRX_LOB_HI:`DRX_LOB_LO];
    s_d.ctrl.mix_vi_bias   = s_q.r_mix[`DRX_VIB_HI:`DRX_VIB_LO];
    s_d.ctrl.mix_a_en      = s_q.r_mix[`DRX_MIXA_BIT];
    s_d.ctrl.mix_b_en      = s_q.r_mix[`DRX_MIXB_BIT];
    s_d.ctrl.amp_a_pd      = s_q.r_amp[`DRX_PDA_BIT];
    s_d.ctrl.amp_b_pd      = s_q.r_amp[`DRX_PDB_BIT];
    s_d.ctrl.gain_src_par  = s_q.r_gsrc[`DRX_GSRC_BIT];
    // gain codes pass through while latch high, else hold; code maps 0.5 dB/step
    // no else branch: a low latch keeps the applied code whatever the source does
    if (s_q.la_s[1]) begin
      s_d.ga = src_a;
    end
    if (s_q.lb_s[1]) begin
      s_d.gb = src_b;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // full bank of sixteen words; readback of the entry that the current select names
  drx_regfile #(
    .NREGS (`DRX_NREGS)
  ) u_rf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (rf_wr),
    .wr_idx  (sel),
    .wr_data (s_q.shift),
    .rd_idx  (sel),
    .rd_data (last_word)
  );

  assign ctrl_out = s_q.ctrl;
  assign gain_a   = s_q.ga;
  assign gain_b   = s_q.gb;

  // shift register takes the sampled bit on every synchronised clock rise
  a_shift_msb_first: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sclk_rise |=> s_q.shift[0] == $past(s_q.l2.sdata))
    else $error("shift lsb wrong");
  a_shift_keeps_old: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sclk_rise |=> s_q.shift[`DRX_WORD_W-1:1] == $past(s_q.shift[`DRX_WORD_W-2:0]))
    else $error("shift history wrong");
  a_shift_idle_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !sclk_rise |=> $stable(s_q.shift))
    else $error("shift moved without clock");
  // a strobe rise copies the word into the one register that its select names
  a_load_gsrc_reg: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    strobe_rise && sel == `DRX_IDX_GSRC |=> s_q.r_gsrc == $past(s_q.shift))
    else $error("reg7 not loaded");
  a_load_mix_reg: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    strobe_rise && sel == `DRX_IDX_MIX |=> s_q.r_mix == $past(s_q.shift))
    else $error("reg13 not loaded");
  a_load_amp_reg: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    strobe_rise && sel == `DRX_IDX_AMP |=> s_q.r_amp == $past(s_q.shift))
    else $error("reg14 not loaded");
  a_load_only_one: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    strobe_rise && sel != `DRX_IDX_AMP |=> $stable(s_q.r_amp))
    else $error("reg14 loaded wrongly");
  a_load_mix_only: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(strobe_rise && sel == `DRX_IDX_MIX) |=> $stable(s_q.r_mix))
    else $error("reg13 loaded wrongly");
  a_load_gsrc_only: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(strobe_rise && sel == `DRX_IDX_GSRC) |=> $stable(s_q.r_gsrc))
    else $error("reg7 loaded wrongly");
  // every analog control is the registered copy of its field, one cycle on
  a_balun_cutoffs: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.balun_in_cut == $past(s_q.r_mix[`DRX_CIN_HI:`DRX_CIN_LO]) &&
             ctrl_out.balun_out_cut == $past(s_q.r_mix[`DRX_COUT_HI:`DRX_COUT_LO]))
    else $error("balun cutoff fields");
  a_mixer_lo_bias: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.mix_lo_bias == $past(s_q.r_mix[`DRX_LOB_HI:`DRX_LOB_LO]))
    else $error("mixer lo bias");
  a_mixer_vi_bias: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.mix_vi_bias == $past(s_q.r_mix[`DRX_VIB_HI:`DRX_VIB_LO]))
    else $error("mixer v to i bias");
  a_mixer_enable: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.mix_a_en == $past(s_q.r_mix[`DRX_MIXA_BIT]))
    else $error("mixer a enable");
  a_mixer_b_enable: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.mix_b_en == $past(s_q.r_mix[`DRX_MIXB_BIT]))
    else $error("mixer b enable");
  a_amp_powerdown: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.amp_b_pd == $past(s_q.r_amp[`DRX_PDB_BIT]))
    else $error("amp b power down");
  a_amp_a_powerdown: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.amp_a_pd == $past(s_q.r_amp[`DRX_PDA_BIT]))
    else $error("amp a power down");
  a_gain_source: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> ctrl_out.gain_src_par == $past(s_q.r_gsrc[`DRX_GSRC_BIT]))
    else $error("gain source select");
  // gain outputs follow their source while latched and freeze otherwise
  a_gain_hold_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !s_q.lb_s[1] |=> $stable(gain_b))
    else $error("gain b changed with latch low");
  a_gain_a_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !s_q.la_s[1] |=> $stable(gain_a))
    else $error("gain a changed with latch low");
  a_gain_par_path: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_q.lb_s[1] && s_q.r_gsrc[`DRX_GSRC_BIT] |=> gain_b == $past(s_q.pb2))
    else $error("parallel gain b");
  a_gain_a_par: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_q.la_s[1] && s_q.r_gsrc[`DRX_GSRC_BIT] |=> gain_a == $past(s_q.pa2))
    else $error("parallel gain a");
  a_gain_ser_path: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_q.lb_s[1] && !s_q.r_gsrc[`DRX_GSRC_BIT] |=> gain_b == $past(s_q.r_amp[`DRX_GB_HI:`DRX_GB_LO]))
    else $error("serial gain b");
  a_gain_a_ser: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_q.la_s[1] && !s_q.r_gsrc[`DRX_GSRC_BIT] |=> gain_a == $past(s_q.r_amp[`DRX_GA_HI:`DRX_GA_LO]))
    else $error("serial gain a");
endmodule

/* verilog/drx_regs.svh */
// register offsets, field positions and reset values of the serial control bank
// assumes: included by bare name from the package and the design modules
`ifndef DRX_REGS_SVH
`define DRX_REGS_SVH
`define DRX_WORD_W      32
`define DRX_NREGS       16
`define DRX_SEL_W       4
`define DRX_SEL_HI      3
`define DRX_SEL_LO      0
`define DRX_IDX_GSRC    4'h7
`define DRX_IDX_MIX     4'hD
`define DRX_IDX_AMP     4'hE
`define DRX_GSRC_BIT    22
`define DRX_CIN_HI      12
`define DRX_CIN_LO      10
`define DRX_COUT_HI     9
`define DRX_COUT_LO     7
`define DRX_LOB_HI      26
`define DRX_LOB_LO      25
`define DRX_VIB_HI      24
`define DRX_VIB_LO      22
`define DRX_MIXA_BIT    5
`define DRX_MIXB_BIT    4
`define DRX_GA_HI       17
`define DRX_GA_LO       12
`define DRX_GB_HI       11
`define DRX_GB_LO       6
`define DRX_PDA_BIT     5
`define DRX_PDB_BIT     4
`define DRX_GAIN_W      6
`define DRX_REG_RST     32'h0000_0000
`define DRX_GAIN_RST    6'h00
`endif

/* verilog/drx_pkg.sv */
// types shared by the serial control bank
// assumes: drx_regs.svh on the include path
`include "drx_regs.svh"
package drx_pkg;
  typedef logic [`DRX_WORD_W-1:0] drx_word_t;
  typedef logic [`DRX_GAIN_W-1:0] drx_gain_t;
  // serial link pins
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load_strobe;
  } drx_link_t;
  // analog control outputs
  typedef struct packed {
    logic [2:0] balun_in_cut;
    logic [2:0] balun_out_cut;
    logic [1:0] mix_lo_bias;
    logic [2:0] mix_vi_bias;
    logic       mix_a_en;
    logic       mix_b_en;
    logic       amp_a_pd;
    logic       amp_b_pd;
    logic       gain_src_par;
  } drx_ctrl_t;
endpackage

/* verilog/drx_regfile.sv */
// sixteen-word register file written from the serial shift register
// assumes: one write port on sys_clk, registered read data
`timescale 1ns/1ns
`include "drx_regs.svh"
module drx_regfile #(
  parameter int NREGS = `DRX_NREGS
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // write port
  input  wire logic                   wr_en,
  input  wire logic [`DRX_SEL_W-1:0]  wr_idx,
  input  wire drx_pkg::drx_word_t     wr_data,
  // read port
  input  wire logic [`DRX_SEL_W-1:0]  rd_idx,
  output drx_pkg::drx_word_t          rd_data
);
  import drx_pkg::*;
  typedef struct packed {
    drx_word_t [NREGS-1:0] mem;
    drx_word_t             rd;
  } drx_rf_state_t;
  drx_rf_state_t s_q, s_d;

  // exactly one word changes per load; read data registered
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_idx] = wr_data;
    end
    s_d.rd = s_q.mem[rd_idx];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd;
endmodule

/* test/drx_host.sv */
// host model: serial link, parallel gain pins and gain latches
// assumes: sys_clk from the bench; link clock 125 ns, parked low outside frames
`timescale 1ns/1ns
module drx_host (
  // clock
  input  wire logic          sys_clk,
  // pins toward the bank
  output drx_pkg::drx_link_t link,
  output drx_pkg::drx_gain_t pa,
  output drx_pkg::drx_gain_t pb,
  output logic               la,
  output logic               lb
);
  import drx_pkg::*;
  // all pins idle at time zero
  initial begin
    link = '0;
    pa = '0;
    pb = '0;
    la = 1'b0;
    lb = 1'b0;
  end
  // shift n bits msb first; data moves while the clock is low so it is stable at the rise
  task automatic put_bits(input logic [39:0] v, input int n);
    #2; // step off the sys_clk edges so that no link pin moves on a sampling edge
    for (int i = n - 1; i >= 0; i--) begin
      link.sdata = v[i];
      #62 link.sclk = 1'b1;
      #63 link.sclk = 1'b0;
    end
    link.sdata = ~v[0]; // released data line shows no stale bit
  endtask
  // commit with the link clock parked low, well clear of its last fall
  task automatic strobe();
    #40 link.load_strobe = 1'b1;
    #60 link.load_strobe = 1'b0;
  endtask
  // gain code first, latch one cycle later
  task automatic gains(input drx_gain_t a, input drx_gain_t b, input logic lat_a, input logic lat_b);
    @(negedge sys_clk);
    pa = a;
    pb = b;
    @(negedge sys_clk);
    la = lat_a;
    lb = lat_b;
  endtask
endmodule

/* test/tb.sv */
// self-checking bench of the serial control bank
// assumes: drx_host drives every pin of the bank except sys_clk and rst_n
`timescale 1ns/1ns
module tb;
  import drx_pkg::*;
  typedef struct { drx_word_t w; logic [3:0] idx; } drx_row_t;
  logic      sys_clk;
  logic      rst_n;
  drx_link_t link;
  drx_gain_t pa, pb, gain_a, gain_b;
  logic      la, lb;
  drx_ctrl_t ctrl_out;
  drx_word_t last_word;
  int        err_total;
  int        n_tests;
  drx_word_t mem [16];
  drx_row_t  rows [6] = '{'{32'h0500_152D, 4'hD}, '{32'h0002_A57E, 4'hE}, '{32'h0040_0007, 4'h7},
                          '{32'h02C0_0A9D, 4'hD}, '{32'hFFFF_FFF5, 4'h5}, '{32'hFFBF_FFF7, 4'h7}};
  drx_host u_host (.sys_clk(sys_clk), .link(link), .pa(pa), .pb(pb), .la(la), .lb(lb));
  drx_ctrl_bank u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_in(link), .par_gain_a(pa), .par_gain_b(pb),
                       .gain_latch_a(la), .gain_latch_b(lb), .ctrl_out(ctrl_out), .gain_a(gain_a),
                       .gain_b(gain_b), .last_word(last_word));
  // expected analog controls from the bench's own copy of the bank
  function automatic drx_ctrl_t exp_ctrl();
    drx_ctrl_t e;
    e.balun_in_cut  = mem[13][12:10];
    e.balun_out_cut = mem[13][9:7];
    e.mix_lo_bias   = mem[13][26:25];
    e.mix_vi_bias   = mem[13][24:22];
    e.mix_a_en      = mem[13][5];
    e.mix_b_en      = mem[13][4];
    e.amp_a_pd      = mem[14][5];
    e.amp_b_pd      = mem[14][4];
    e.gain_src_par  = mem[7][22];
    return e;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one frame of nbits (leading pre bits first), commit, then check the bank
  task automatic do_word(input drx_word_t w, input int nbits, input logic [7:0] pre, input logic [3:0] idx);
    u_host.put_bits({pre, w}, nbits);
    u_host.strobe();
    mem[idx] = w;
    repeat (10) @(negedge sys_clk);
    chk("last_word", last_word, w);
    chk("ctrl_out", ctrl_out, exp_ctrl());
  endtask
  // shift a bare select value without committing; the bank shows that entry
  task automatic peek(input logic [3:0] idx);
    u_host.put_bits({36'h0, idx}, 32);
    repeat (10) @(negedge sys_clk);
    chk("last_word", last_word, mem[idx]);
  endtask
  // gain pins, then settle past the latch synchroniser
  task automatic gain_step(input drx_gain_t a, input drx_gain_t b, input logic xa, input logic xb);
    u_host.gains(a, b, xa, xb);
    repeat (8) @(negedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog well beyond the expected run of about 12700 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    err_total = 0;
    n_tests = 0;
    foreach (mem[i]) mem[i] = '0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("ctrl_out", ctrl_out, 32'h0);
    chk("gain_a", gain_a, 32'h0);
    chk("gain_b", gain_b, 32'h0);
    chk("last_word", last_word, 32'h0);
    // every select value once, so all sixteen entries are addressed
    for (int i = 0; i < 16; i++) do_word({28'(i * 28'h13579BD) ^ 28'hA5C3F0E, 4'(i)}, 32, 8'h00, 4'(i));
    // read back stored entries by select alone, so a wrong index decode shows
    for (int k = 0; k < 16; k += 5) peek(4'(k));
    foreach (rows[r]) do_word(rows[r].w, 32, 8'h00, rows[r].idx);
    chk("gain_a", gain_a, 32'h0);
    gain_step(6'h00, 6'h00, 1'b1, 1'b0);
    chk("gain_a", gain_a, 32'h2A);
    chk("gain_b", gain_b, 32'h0);
    do_word(32'h0040_0007, 32, 8'h00, 4'h7);
    gain_step(6'h3F, 6'h01, 1'b1, 1'b0);
    chk("gain_a", gain_a, 32'h3F);
    chk("gain_b", gain_b, 32'h0);
    gain_step(6'h3F, 6'h01, 1'b1, 1'b1);
    chk("gain_b", gain_b, 32'h01);
    // latches drop first; pins that move afterwards must not reach the outputs
    gain_step(6'h3F, 6'h01, 1'b0, 1'b0);
    gain_step(6'h05, 6'h07, 1'b0, 1'b0);
    chk("gain_a", gain_a, 32'h3F);
    chk("gain_b", gain_b, 32'h01);
    // back to serial codes with only channel b latched
    do_word(32'h0000_0007, 32, 8'h00, 4'h7);
    gain_step(6'h05, 6'h07, 1'b0, 1'b1);
    chk("gain_b", gain_b, 32'h15);
    chk("gain_a", gain_a, 32'h3F);
    // eight extra leading bits must fall out of the shift register
    do_word(32'h0123_4565, 40, 8'hFF, 4'h5);
    // reset in mid-run clears every output and every register
    rst_n = 1'b0;
    foreach (mem[i]) mem[i] = '0;
    repeat (2) @(negedge sys_clk);
    chk("ctrl_out", ctrl_out, 32'h0);
    chk("gain_a", gain_a, 32'h0);
    chk("gain_b", gain_b, 32'h0);
    chk("last_word", last_word, 32'h0);
    rst_n = 1'b1;
    // idle pins after release must not look like a clock or strobe edge
    repeat (2) @(negedge sys_clk);
    chk("ctrl_out", ctrl_out, 32'h0);
    chk("gain_b", gain_b, 32'h0);
    chk("last_word", last_word, 32'h0);
    do_word(32'h0500_152D, 32, 8'h00, 4'hD);
    summarize();
  end
endmodule
